// ===== pkg/psp_params.svh
// Constants for the pipelined burst SRAM port: geometry and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PSP_ADDR_W    17
`define PSP_HI_W      15
`define PSP_LSB_W     2
`define PSP_DATA_W    36
`define PSP_LANES     4
`define PSP_LANE_W    9
`define PSP_DEPTH     131072

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSP_RST_COUNT 2'h0
`define PSP_RST_LSB   2'h0

`endif

// ===== pkg/psp_pkg.sv
// Types shared by the burst SRAM port and its burst address mapper.
// Assumes psp_params.svh is on the include path.
`include "psp_params.svh"

package psp_pkg;

  // ----------------------------------------------------------------
  // Port mode, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSP_MODE_DESEL = 2'b01,
    PSP_MODE_BURST = 2'b10
  } psp_mode_t;

  // ----------------------------------------------------------------
  // Burst position carried to the mapper
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`PSP_LSB_W-1:0] start_lsb;
    logic [`PSP_LSB_W-1:0] count;
  } psp_burst_t;

  // ----------------------------------------------------------------
  // All state of the port
  // ----------------------------------------------------------------
  typedef struct packed {
    psp_mode_t              mode;
    logic [`PSP_HI_W-1:0]   base_hi;
    psp_burst_t             burst;
    logic                   rd_pend;
    logic [`PSP_ADDR_W-1:0] rd_addr;
    logic                   dout_valid;
    logic [`PSP_DATA_W-1:0] dout;
  } psp_state_t;

endpackage : psp_pkg

// ===== core/psp_burst_map.sv
// Burst address mapper: turns start bits and burst count into the low
// address bits. Purely combinational; the order select is a static strap.
`timescale 1ns/10ps
`include "psp_params.svh"

module psp_burst_map #(
  parameter int LSB_W = `PSP_LSB_W
)(
  input  wire logic              order_i,
  input  wire psp_pkg::psp_burst_t burst_i,
  output logic [LSB_W-1:0]       lsb_o
);

  // ----------------------------------------------------------------
  // Linear or interleaved order
  // ----------------------------------------------------------------
  always_comb
  begin
    if (order_i)
    begin
      lsb_o = burst_i.start_lsb ^ burst_i.count;                         // [RQ20] [RQ5]
    end
    else
    begin
      lsb_o = LSB_W'(burst_i.start_lsb + burst_i.count);                 // [RQ20] [RQ5]
    end
  end

endmodule : psp_burst_map

// ===== core/psp_sram_port.sv
// Pipelined burst static RAM port, 128K words of 36 bits, four byte lanes.
// Assumes a single clock, inputs synchronous to it, and a far side that
// keeps the order select steady and wires the burst bits to its LSBs.
//
// How it works
// RQ1 - Array of 128K words, 36 bits, four byte lanes a to d.
// RQ2 - Internal 2-bit counter derives later burst addresses from the start.
// RQ3 - Address, data, controls sampled on clock edge; output enable and order not.
// RQ4 - Either address strobe sampled low starts a new burst.
// RQ5 - Order select low gives linear, high gives interleaved stepping.
// RQ6 - Far side keeps order select fixed; it is never latched.
// RQ7 - Advance sampled low steps the burst count in the chosen order.
// RQ8 - Write starts on its sampling edge and completes with no external pulse.
// RQ9 - Write gate with lane strobes writes only the strobed lanes.
// RQ10 - Global write, or gate with all strobes, writes all four lanes.
// RQ11 - Read data goes through an output register, presented one edge later.
// RQ12 - Controller strobe aborts burst, loads address, reads, writes or deselects.
// RQ13 - Processor strobe aborts burst, loads address, reads, writes or deselects.
// RQ14 - Processor strobe is ignored while primary enable is high.
// RQ15 - Primary enable high with controller strobe deselects the port.
// RQ16 - Output enable acts without the clock; high floats the data pins.
// RQ17 - Far side wires the two burst bits to its address LSBs.
// RQ18 - Expansion enable high is active high and gates selection.
// RQ19 - Expansion enable low is active low and gates selection.
// RQ20 - Linear counts up modulo four; interleaved XORs start with count.
// RQ21 - No strobe and no advance holds the address and repeats the access.
`timescale 1ns/10ps
`include "psp_params.svh"

module psp_sram_port #(
  parameter int ADDR_W = `PSP_ADDR_W,
  parameter int HI_W   = `PSP_HI_W,
  parameter int DATA_W = `PSP_DATA_W,
  parameter int LANES  = `PSP_LANES,
  parameter int LANE_W = `PSP_LANE_W,
  parameter int DEPTH  = `PSP_DEPTH
)(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              CLK_EN_I,
  input  wire logic [HI_W-1:0]   SYNC_ADDR_IN_I,
  input  wire logic [1:0]        BURST_LSB_ADDR_I,
  input  wire logic              PROCESSOR_ADDR_STROBE_N_I,
  input  wire logic              CONTROLLER_ADDR_STROBE_N_I,
  input  wire logic              BURST_ADVANCE_N_I,
  input  wire logic              BURST_ORDER_SELECT_I,
  input  wire logic              GLOBAL_WRITE_N_I,
  input  wire logic              BYTE_WRITE_GATE_N_I,
  input  wire logic [LANES-1:0]  BYTE_LANE_STROBE_N_I,
  input  wire logic              PRIMARY_CHIP_ENABLE_N_I,
  input  wire logic              EXPANSION_ENABLE_HIGH_I,
  input  wire logic              EXPANSION_ENABLE_LOW_N_I,
  input  wire logic              OUTPUT_ENABLE_N_I,
  input  wire logic [DATA_W-1:0] DATA_LANE_I,
  output logic      [DATA_W-1:0] DATA_LANE_O,
  output logic                   DATA_LANE_OE_N_O
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]   mem [0:DEPTH-1];                                  // [RQ1]
  psp_pkg::psp_state_t st;
  psp_pkg::psp_state_t next_st;

  logic                chip_sel;
  logic                proc_start;
  logic                ctrl_start;
  logic                new_burst;
  logic                cont_burst;
  logic                acc;
  logic                acc_wr;
  logic                acc_rd;
  logic [HI_W-1:0]     acc_hi;
  logic [1:0]          acc_lsb;
  logic [ADDR_W-1:0]   acc_addr;
  psp_pkg::psp_burst_t acc_burst;
  logic [LANES-1:0]    lane_we;
  logic [DATA_W-1:0]   bit_mask;

  // ----------------------------------------------------------------
  // Burst start and selection
  // ----------------------------------------------------------------
  // All three enables must agree for a new access to be selected
  assign chip_sel   = !PRIMARY_CHIP_ENABLE_N_I && EXPANSION_ENABLE_HIGH_I
                      && !EXPANSION_ENABLE_LOW_N_I;                      // [RQ18] [RQ19]
  // Processor strobe is dropped entirely with primary enable high
  assign proc_start = !PROCESSOR_ADDR_STROBE_N_I
                      && !PRIMARY_CHIP_ENABLE_N_I;                       // [RQ14] [RQ13]
  assign ctrl_start = !CONTROLLER_ADDR_STROBE_N_I;                       // [RQ12] [RQ15]
  assign new_burst  = proc_start || ctrl_start;                          // [RQ4]
  assign cont_burst = !new_burst && (st.mode == psp_pkg::PSP_MODE_BURST);
  assign acc        = (new_burst && chip_sel) || cont_burst;

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  always_comb
  begin
    if (new_burst)
    begin
      acc_hi              = SYNC_ADDR_IN_I;                              // [RQ12] [RQ13]
      acc_burst.start_lsb = BURST_LSB_ADDR_I;
      acc_burst.count     = `PSP_RST_COUNT;
    end
    else if (!BURST_ADVANCE_N_I)
    begin
      acc_hi              = st.base_hi;
      acc_burst.start_lsb = st.burst.start_lsb;
      acc_burst.count     = 2'(st.burst.count + 2'h1);                   // [RQ7] [RQ2]
    end
    else
    begin
      acc_hi              = st.base_hi;                                  // [RQ21]
      acc_burst           = st.burst;                                    // [RQ21]
    end
  end

  // Order select is used live, never registered
  psp_burst_map #(
    .LSB_W   (2)
  ) u_map (
    .order_i (BURST_ORDER_SELECT_I),                                     // [RQ3] [RQ5]
    .burst_i (acc_burst),
    .lsb_o   (acc_lsb)
  );

  assign acc_addr = {acc_hi, acc_lsb};

  // ----------------------------------------------------------------
  // Byte lane write enables
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      assign lane_we[g] = acc && (!GLOBAL_WRITE_N_I
                          || (!BYTE_WRITE_GATE_N_I && !BYTE_LANE_STROBE_N_I[g])); // [RQ9] [RQ10]
      assign bit_mask[g*LANE_W +: LANE_W] = {LANE_W{lane_we[g]}};
    end
  endgenerate

  // Gate low with no strobes is a write of nothing, not a read
  assign acc_wr = acc && (!GLOBAL_WRITE_N_I || !BYTE_WRITE_GATE_N_I);
  assign acc_rd = acc && !acc_wr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (new_burst)
    begin
      next_st.mode = chip_sel ? psp_pkg::PSP_MODE_BURST
                              : psp_pkg::PSP_MODE_DESEL;                 // [RQ15]
    end
    next_st.base_hi = acc_hi;
    next_st.burst   = acc_burst;
    next_st.rd_pend = acc_rd;
    next_st.rd_addr = acc_addr;
    // Second pipeline stage: array word into the output register
    next_st.dout_valid = st.rd_pend;                                     // [RQ11]
    if (st.rd_pend)
    begin
      next_st.dout = mem[st.rd_addr];                                    // [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      st.mode       <= psp_pkg::PSP_MODE_DESEL;
      st.base_hi    <= '0;
      st.burst      <= {`PSP_RST_LSB, `PSP_RST_COUNT};
      st.rd_pend    <= 1'h0;
      st.rd_addr    <= '0;
      st.dout_valid <= 1'h0;
      st.dout       <= '0;
    end
    else if (CLK_EN_I)
    begin
      st <= next_st;                                                     // [RQ3]
    end
  end

  // Write lands on its own sampling edge; no strobe pulse from outside
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RESET_I && CLK_EN_I && acc_wr)
    begin
      mem[acc_addr] <= (mem[acc_addr] & ~bit_mask)
                       | (DATA_LANE_I & bit_mask);                       // [RQ8] [RQ9]
    end
  end

  // ----------------------------------------------------------------
  // Data pins
  // ----------------------------------------------------------------
  assign DATA_LANE_O      = st.dout;
  // Deliberate async path: the enable pin is not clocked
  assign DATA_LANE_OE_N_O = OUTPUT_ENABLE_N_I || !st.dout_valid;         // [RQ16]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  a_start_latch: assert property (                                      // [RQ4]
    CLK_EN_I && new_burst && chip_sel |=> st.mode == psp_pkg::PSP_MODE_BURST
      && st.base_hi == $past(SYNC_ADDR_IN_I) && st.burst.count == 2'h0)
    else $error("new burst did not load address");

  a_proc_ignored: assert property (                                     // [RQ14]
    CLK_EN_I && !PROCESSOR_ADDR_STROBE_N_I && PRIMARY_CHIP_ENABLE_N_I
      && CONTROLLER_ADDR_STROBE_N_I && st.mode == psp_pkg::PSP_MODE_BURST
      |=> st.mode == psp_pkg::PSP_MODE_BURST)
    else $error("processor strobe deselected with enable high");

  a_ctrl_desel: assert property (                                       // [RQ15]
    CLK_EN_I && !CONTROLLER_ADDR_STROBE_N_I && PRIMARY_CHIP_ENABLE_N_I
      |=> st.mode == psp_pkg::PSP_MODE_DESEL ##1 !st.dout_valid)
    else $error("controller strobe failed to deselect");

  a_expand_gate: assert property (                                      // [RQ18]
    CLK_EN_I && new_burst && (!EXPANSION_ENABLE_HIGH_I || EXPANSION_ENABLE_LOW_N_I)
      |-> !acc && !(|lane_we))                                           // [RQ19]
    else $error("access taken with expansion enables off");

  a_advance_step: assert property (                                     // [RQ7]
    CLK_EN_I && cont_burst && !BURST_ADVANCE_N_I
      |=> st.burst.count == 2'($past(st.burst.count) + 2'h1))
    else $error("advance did not step the count");

  a_hold_addr: assert property (                                        // [RQ21]
    CLK_EN_I && cont_burst && BURST_ADVANCE_N_I
      |=> $stable(st.burst) && $stable(st.base_hi))
    else $error("address moved without advance");

  a_linear_order: assert property (                                     // [RQ20]
    acc && !BURST_ORDER_SELECT_I
      |-> acc_lsb == 2'(acc_burst.start_lsb + acc_burst.count))
    else $error("linear order wrong");

  a_interleave: assert property (                                       // [RQ5]
    acc && BURST_ORDER_SELECT_I
      |-> acc_lsb == (acc_burst.start_lsb ^ acc_burst.count))
    else $error("interleaved order wrong");

  a_lane_write: assert property (                                       // [RQ9]
    acc && GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I
      |-> lane_we == ~BYTE_LANE_STROBE_N_I)
    else $error("byte lanes written wrongly");

  a_global_write: assert property (                                     // [RQ10]
    acc && !GLOBAL_WRITE_N_I |-> lane_we == 4'hf && acc_wr)
    else $error("global write missed a lane");

  a_write_lands: assert property (                                      // [RQ8]
    CLK_EN_I && acc_wr && lane_we[0] |=> mem[$past(acc_addr)][LANE_W-1:0]
      == $past(DATA_LANE_I[LANE_W-1:0]))
    else $error("lane a write did not land");

  a_read_pipe: assert property (                                        // [RQ11]
    CLK_EN_I && acc_rd ##1 CLK_EN_I |=> st.dout_valid)
    else $error("read data not presented two edges on");

  a_oe_float: assert property (                                         // [RQ16]
    OUTPUT_ENABLE_N_I || !st.dout_valid |-> DATA_LANE_OE_N_O)
    else $error("data pins driven while disabled");

  // Frozen edges must leave every state bit alone
  a_clock_freeze: assert property (                                     // [RQ3]
    !CLK_EN_I |=> $stable(st))
    else $error("state moved with clock enable low");

  a_proc_start: assert property (                                       // [RQ13]
    CLK_EN_I && proc_start && CONTROLLER_ADDR_STROBE_N_I && chip_sel
      |=> st.mode == psp_pkg::PSP_MODE_BURST && st.burst.start_lsb == $past(BURST_LSB_ADDR_I))
    else $error("processor strobe did not start a burst");

  a_empty_gate: assert property (                                       // [RQ9]
    acc && GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I && (&BYTE_LANE_STROBE_N_I)
      |-> acc_wr && !acc_rd && lane_we == '0)
    else $error("gate with no strobes changed a lane");

  a_desel_quiet: assert property (                                      // [RQ15]
    CLK_EN_I && st.mode == psp_pkg::PSP_MODE_DESEL && !new_burst ##1 CLK_EN_I
      |=> !st.dout_valid)
    else $error("deselected port presented read data");

  c_read_burst: cover property (
    CLK_EN_I && acc_rd && new_burst ##1 (CLK_EN_I && acc_rd && !BURST_ADVANCE_N_I) [*3]);
  c_lane_write: cover property (
    acc && GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I && lane_we == 4'h5);
  c_proc_ignored: cover property (
    !PROCESSOR_ADDR_STROBE_N_I && PRIMARY_CHIP_ENABLE_N_I && cont_burst);
  c_interleave_wrap: cover property (
    acc && BURST_ORDER_SELECT_I && acc_burst.count == 2'h3 && acc_burst.start_lsb == 2'h2);

endmodule : psp_sram_port

// ===== verification/psp_host_model.sv
// Far-side model: a cache controller that drives the burst port pins.
// Assumes the bench calls drive once per cycle, set_order and set_enable only while idle.
`timescale 1ns/10ps

module psp_host_model (
  input  wire logic        clk_i,
  output logic             clk_en_o,
  output logic [14:0]      addr_hi_o,
  output logic [1:0]       addr_lsb_o,
  output logic             proc_strobe_n_o,
  output logic             ctrl_strobe_n_o,
  output logic             advance_n_o,
  output logic             order_o,
  output logic             global_write_n_o,
  output logic             write_gate_n_o,
  output logic [3:0]       lane_strobe_n_o,
  output logic             primary_n_o,
  output logic             exp_high_o,
  output logic             exp_low_n_o,
  output logic [35:0]      wdata_o
);
  initial
  begin
    clk_en_o = 1'b1;
    {ctrl_strobe_n_o, proc_strobe_n_o, advance_n_o, global_write_n_o, write_gate_n_o} = 5'h1f;
    {primary_n_o, exp_high_o, exp_low_n_o} = 3'h2;
    {addr_hi_o, addr_lsb_o} = 17'h0;
    lane_strobe_n_o = 4'hf;
    order_o = 1'b0;
    wdata_o = 36'h0;
  end

  // ----------------------------------------------------------------
  // One bus cycle: c = strobe, proc, advance, global, gate, enables
  // ----------------------------------------------------------------
  task automatic drive(input logic [7:0] c, input logic [3:0] sb, input logic [16:0] a, input logic [35:0] d);
    @(posedge clk_i);
    {ctrl_strobe_n_o, proc_strobe_n_o} <= c[7:6];
    advance_n_o <= c[5];
    {global_write_n_o, write_gate_n_o} <= c[4:3];
    {primary_n_o, exp_high_o, exp_low_n_o} <= c[2:0];
    lane_strobe_n_o <= sb;
    {addr_hi_o, addr_lsb_o} <= a;
    // Released bus toggles so a stale word can never pass for data
    wdata_o <= (!c[4] || !c[3]) ? d : ~wdata_o;
    #1;
  endtask : drive

  task automatic set_order(input logic o);
    @(posedge clk_i);
    order_o <= o;
    #1;
  endtask : set_order

  task automatic set_enable(input logic e);
    @(posedge clk_i);
    clk_en_o <= e;
    #1;
  endtask : set_enable
endmodule : psp_host_model

// ===== verification/psp_sram_port_tb_top.sv
// Self-checking bench for the burst port with a reference model of the array.
// Assumes the host model drives every synchronous pin; bench owns reset and OE.
`timescale 1ns/10ps

module psp_sram_port_tb_top;
  logic core_clk = 1'b0;
  logic reset    = 1'b1;
  logic oe_n     = 1'b0;
  logic clk_en, ps_n, cs_n, adv_n, ord_pin, gw_n, gate_n, pce_n, e_hi, e_lo_n;
  logic [14:0] a_hi;
  logic [1:0]  a_lsb;
  logic [3:0]  sb_n;
  logic [35:0] wd, rdata;
  logic        rd_oe_n;
  int          err_total   = 0;
  int          checks_done = 0;
  logic [2:0]  en      = 3'h2;
  logic        ord     = 1'b0;
  logic        r_burst = 1'b0;
  logic [16:0] r_base  = 17'h0;
  logic [1:0]  r_cnt   = 2'h0;
  logic [35:0] mem [int];
  logic [1:0]  ev = 2'h0;
  logic [35:0] ed [2];
  logic        run = 1'b1;

  always #4 core_clk = ~core_clk;

  psp_host_model psp_host_model_i (.clk_i(core_clk), .clk_en_o(clk_en), .addr_hi_o(a_hi), .addr_lsb_o(a_lsb),
    .proc_strobe_n_o(ps_n), .ctrl_strobe_n_o(cs_n), .advance_n_o(adv_n), .order_o(ord_pin),
    .global_write_n_o(gw_n), .write_gate_n_o(gate_n), .lane_strobe_n_o(sb_n), .primary_n_o(pce_n),
    .exp_high_o(e_hi), .exp_low_n_o(e_lo_n), .wdata_o(wd));

  psp_sram_port psp_sram_port_i (.CORE_CLK_I(core_clk), .RESET_I(reset), .CLK_EN_I(clk_en),
    .SYNC_ADDR_IN_I(a_hi), .BURST_LSB_ADDR_I(a_lsb), .PROCESSOR_ADDR_STROBE_N_I(ps_n),
    .CONTROLLER_ADDR_STROBE_N_I(cs_n), .BURST_ADVANCE_N_I(adv_n), .BURST_ORDER_SELECT_I(ord_pin),
    .GLOBAL_WRITE_N_I(gw_n), .BYTE_WRITE_GATE_N_I(gate_n), .BYTE_LANE_STROBE_N_I(sb_n),
    .PRIMARY_CHIP_ENABLE_N_I(pce_n), .EXPANSION_ENABLE_HIGH_I(e_hi), .EXPANSION_ENABLE_LOW_N_I(e_lo_n),
    .OUTPUT_ENABLE_N_I(oe_n), .DATA_LANE_I(wd), .DATA_LANE_O(rdata), .DATA_LANE_OE_N_O(rd_oe_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      $display("BAD %0t %s", $time, msg);
      err_total++;
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One cycle; c = strobe, proc, advance, global, gate. Read results land two calls later.
  task automatic step(input logic [4:0] c, input logic [3:0] sb, input logic [16:0] a, input logic [35:0] d);
    logic sel, nb, acc, rd;
    logic [16:0] ad;
    logic [35:0] m, q;
    sel = !en[2] && en[1] && !en[0];
    nb  = !c[4] || (!c[3] && !en[2]);
    acc = 1'b0;
    if (nb && run)
    begin
      r_burst = sel;
      r_base  = a;
      r_cnt   = 2'h0;
      acc     = sel;
    end
    else if (r_burst && run)
    begin
      r_cnt = r_cnt + (c[2] ? 2'h0 : 2'h1);
      acc   = 1'b1;
    end
    ad = {r_base[16:2], ord ? (r_base[1:0] ^ r_cnt) : (r_base[1:0] + r_cnt)};
    rd = acc && c[1] && c[0];
    if (acc && !rd)
    begin
      m = !c[1] ? {36{1'b1}} : {{9{!sb[3]}}, {9{!sb[2]}}, {9{!sb[1]}}, {9{!sb[0]}}};
      q = mem.exists(ad) ? mem[ad] : 36'h0;
      mem[ad] = (q & ~m) | (d & m);
    end
    psp_host_model_i.drive({c, en}, sb, a, d);
    chk(rd_oe_n === (oe_n | !ev[1]), "output enable");
    if (ev[1])
      chk(rdata === ed[1], "read data");
    ev = {ev[0], rd};
    ed[1] = ed[0];
    ed[0] = rd ? mem[ad] : 36'h0;
  endtask : step

  task automatic rd(input logic [16:0] a);  step(5'h0f, 4'hf, a, 36'h0);  endtask : rd
  task automatic nx();  step(5'h1b, 4'hf, 17'h0, 36'h0);  endtask : nx
  task automatic gwr(input logic [16:0] a, input logic [35:0] d);  step(5'h0d, 4'hf, a, d);  endtask : gwr
  task automatic desel();
    en = 3'h6;
    rd(17'h0);
    en = 3'h2;
    repeat (3) step(5'h1f, 4'hf, 17'h0, 36'h0);
  endtask : desel

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(rdata === 36'h0 && rd_oe_n === 1'b1, "reset outputs");
  endtask : t_reset

  task automatic t_linear();
    for (int i = 0; i < 4; i++)
      gwr(17'h100 + 17'(i), 36'h123456780 + 36'(i));
    rd(17'h102);
    repeat (4) nx();
    desel();
  endtask : t_linear

  task automatic t_interleave();
    psp_host_model_i.set_order(1'b1);
    ord = 1'b1;
    rd(17'h102);
    repeat (3) nx();
    desel();
    psp_host_model_i.set_order(1'b0);
    ord = 1'b0;
  endtask : t_interleave

  task automatic t_lanes();
    gwr(17'h200, 36'h0);
    step(5'h0e, 4'ha, 17'h200, 36'hfffffffff);
    step(5'h0e, 4'h0, 17'h201, 36'h5a5a5a5a5);
    gwr(17'h202, 36'h0f0f0f0f0);
    step(5'h0e, 4'hf, 17'h202, 36'hfffffffff);
    step(5'h0c, 4'hf, 17'h203, 36'h987654321);
    rd(17'h200);
    repeat (3) nx();
    desel();
  endtask : t_lanes

  task automatic t_proc();
    step(5'h17, 4'hf, 17'h100, 36'h0);
    nx();
    en = 3'h6;
    step(5'h13, 4'hf, 17'h200, 36'h0);
    en = 3'h2;
    step(5'h1f, 4'hf, 17'h0, 36'h0);
    desel();
  endtask : t_proc

  task automatic t_select();
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++)
    begin
      rd(17'h100);
      en = bad[i];
      rd(17'h101);
      en = 3'h2;
      repeat (3) nx();
    end
  endtask : t_select

  task automatic t_oe();
    rd(17'h100);
    repeat (3) step(5'h1f, 4'hf, 17'h0, 36'h0);
    @(negedge core_clk);
    oe_n = 1'b1;
    #1 chk(rd_oe_n === 1'b1, "output enable off");
    oe_n = 1'b0;
    #1 chk(rd_oe_n === 1'b0, "output enable on");
    desel();
  endtask : t_oe

  // Frozen clock enable: a full write must not land, reads resume after
  task automatic t_freeze();
    psp_host_model_i.set_enable(1'b0);
    run = 1'b0;
    gwr(17'h100, 36'h0badc0de1);
    nx();
    psp_host_model_i.set_enable(1'b1);
    run = 1'b1;
    rd(17'h100);
    repeat (2) nx();
    desel();
  endtask : t_freeze

  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_linear();
    t_interleave();
    t_lanes();
    t_proc();
    t_select();
    t_oe();
    t_freeze();
    end_sim();
  end

  // Hang guard
  initial
  begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : psp_sram_port_tb_top
